/* File: rtl/bridge_audio_cfg_link_status_regs.v */
// audio configuration and link/input status registers of the bridge serializer
//
// Overview of operation
// RQ1 - Bit 7 of audio_config turns on the multichannel-to-parallel audio converter.
// RQ2 - While that converter is on, its clock is selected to carry audio downstream.
// RQ3 - Bit 6 of audio_config echoes the recovered input audio onto the local I2S pins.
// RQ4 - That echo is ignored unless audio_source_select picks audio from the video input.
// RQ5 - Bit 3 clears the input audio FIFO whenever the received audio type changes.
// RQ6 - Bit 2 clears the input audio FIFO whenever the audio infoframe checksum changes.
// RQ7 - Bit 1 clears the input audio FIFO whenever the video information infoframe checksum changes.
// RQ8 - Bit 0 clears the input audio FIFO whenever N or CTS of a clock regeneration packet changes.
// RQ9 - Status bit 7 shows that a downstream connection was found and its abilities learned.
// RQ10 - Status bit 6 shows the transmitter active with the far receiver locked to its clock.
// RQ11 - Status bit 6 stays low until a valid input is seen and single or dual mode has settled.
// RQ12 - While bit 6 is set, bits 5:4 give dual, single port 0, single port 1 or replicate mode.
// RQ13 - Status bit 3 shows that valid encoded symbols are being recovered from the input.
// RQ14 - Status bit 2 shows the input PLL locked to the incoming video clock.
// RQ15 - Status bit 0 shows that the input clock frequency has been found stable.
// RQ16 - audio_source_select picks video-input audio (0) or local I2S pin audio (1) for downstream.
// RQ17 - Reserved bits 5:4 of audio_config read zero and writes to the status register are dropped.
`timescale 1ns/1ps
`include "bridge_audio_defines.vh"
module bridge_audio_cfg_link_status_regs (
  input wire clk,
  input wire rst_b,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire reg_rd_en,
  output reg [7:0] reg_rd_data,
  // audio source choice held in the bridge configuration register
  input wire audio_source_select,
  // audio control outputs
  output wire tdm_parallel_convert_en,
  output wire audio_clk_from_converter,
  output reg audio_fifo_clear,
  // recovered input audio (same clock)
  input wire rx_i2s_sck,
  input wire rx_i2s_ws,
  input wire rx_i2s_sd,
  // local I2S pins, two-way
  input wire i2s_sck_in,
  input wire i2s_ws_in,
  input wire i2s_sd_in,
  output reg i2s_sck_out,
  output reg i2s_ws_out,
  output reg i2s_sd_out,
  output wire i2s_oe,
  // audio selected for the downstream link
  output reg tx_i2s_sck,
  output reg tx_i2s_ws,
  output reg tx_i2s_sd,
  // received packet fields (same clock, with strobes)
  input wire audio_kind_vld,
  input wire [3:0] audio_kind,
  input wire audio_info_vld,
  input wire [7:0] audio_info_checksum,
  input wire video_info_vld,
  input wire [7:0] video_info_checksum,
  input wire clk_regen_vld,
  input wire [19:0] clk_regen_n,
  input wire [19:0] clk_regen_cts,
  // raw status from link and input front end (asynchronous)
  input wire link_detect_done,
  input wire serial_tx_active,
  input wire far_rx_locked,
  input wire valid_input_seen,
  input wire link_mode_settled,
  input wire [1:0] link_port_mode,
  input wire symbol_recovery_ok,
  input wire input_pll_lock_raw,
  input wire freq_detect_stable
);

  // ************************************************************
  // declarations
  // ************************************************************
  reg [7:0] audio_config_r;
  reg [7:0] audio_config_nxt;
  reg [7:0] link_status_r;
  reg [7:0] link_status_nxt;
  reg [7:0] rd_data_nxt;
  reg [3:0] last_kind_r;
  reg kind_seen_r;
  reg [7:0] last_audio_info_r;
  reg audio_info_seen_r;
  reg [7:0] last_video_info_r;
  reg video_info_seen_r;
  reg [19:0] last_n_r;
  reg [19:0] last_cts_r;
  reg regen_seen_r;
  wire [`STATUS_SYNC_W-1:0] status_raw;
  wire [`STATUS_SYNC_W-1:0] status_sync;
  wire [`I2S_W-1:0] pins_raw;
  wire [`I2S_W-1:0] pins_sync;
  wire sel_audio_config;
  wire sel_link_status;
  wire echo_allowed;
  wire kind_changed;
  wire audio_info_changed;
  wire video_info_changed;
  wire regen_changed;
  wire clear_request;
  wire st_link_ready;
  wire st_tx_active;
  wire st_rx_locked;
  wire st_input_seen;
  wire st_mode_settled;
  wire [1:0] st_port_mode;
  wire st_symbols_ok;
  wire st_pll_lock;
  wire st_input_freq_settled;
  wire tx_locked_now;

  // ************************************************************
  // crossings of asynchronous inputs
  // ************************************************************
  // status levels from the analog and link front end
  assign status_raw = {link_detect_done, serial_tx_active, far_rx_locked, valid_input_seen,
                       link_mode_settled, link_port_mode, symbol_recovery_ok,
                       input_pll_lock_raw, freq_detect_stable};
  sync2 #(
    .WIDTH(`STATUS_SYNC_W)
  ) u_status_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(status_raw),
    .sync_out(status_sync)
  );
  assign st_link_ready = status_sync[9];
  assign st_tx_active = status_sync[8];
  assign st_rx_locked = status_sync[7];
  assign st_input_seen = status_sync[6];
  assign st_mode_settled = status_sync[5];
  assign st_port_mode = status_sync[4:3];
  assign st_symbols_ok = status_sync[2];
  assign st_pll_lock = status_sync[1];
  assign st_input_freq_settled = status_sync[0];

  // local I2S pins seen as inputs
  assign pins_raw = {i2s_sck_in, i2s_ws_in, i2s_sd_in};

  sync2 #(
    .WIDTH(`I2S_W)
  ) u_pin_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // ************************************************************
  // register port decode and write path
  // ************************************************************
  assign sel_audio_config = (reg_addr == `AUDIO_CONFIG_OFFSET);
  assign sel_link_status = (reg_addr == `LINK_STATUS_OFFSET);

  // next value of audio_config
  always @* begin
    audio_config_nxt = audio_config_r;
    if (reg_wr_en && sel_audio_config) begin
      // RQ17 reserved bits dropped
      audio_config_nxt = reg_wr_data & `CFG_WRITABLE_MASK;
    end
  end

  // audio_config storage
  always @(posedge clk) begin
    if (!rst_b) begin
      audio_config_r <= `AUDIO_CONFIG_RESET;
    end else begin
      audio_config_r <= audio_config_nxt;
    end
  end

  // ************************************************************
  // audio routing
  // ************************************************************
  // RQ1 converter enable
  assign tdm_parallel_convert_en = audio_config_r[`CFG_TDM_PARALLEL_BIT];
  // RQ2 converter clock select
  assign audio_clk_from_converter = audio_config_r[`CFG_TDM_PARALLEL_BIT];
  // RQ4 echo only with video-input source
  assign echo_allowed = audio_config_r[`CFG_SRC_PIN_OUT_BIT] &&
                        (audio_source_select == `AUDIO_SRC_VIDEO_INPUT);

  // RQ3 pins driven while echoing
  assign i2s_oe = echo_allowed;

  // RQ3 recovered audio onto pins
  always @(posedge clk) begin
    if (!rst_b) begin
      i2s_sck_out <= 1'b0;
      i2s_ws_out <= 1'b0;
      i2s_sd_out <= 1'b0;
    end else if (echo_allowed) begin
      i2s_sck_out <= rx_i2s_sck;
      i2s_ws_out <= rx_i2s_ws;
      i2s_sd_out <= rx_i2s_sd;
    end else begin
      i2s_sck_out <= 1'b0;
      i2s_ws_out <= 1'b0;
      i2s_sd_out <= 1'b0;
    end
  end

  // RQ16 downstream audio source select
  always @(posedge clk) begin
    if (!rst_b) begin
      tx_i2s_sck <= 1'b0;
      tx_i2s_ws <= 1'b0;
      tx_i2s_sd <= 1'b0;
    end else if (audio_source_select == `AUDIO_SRC_LOCAL_PINS) begin
      tx_i2s_sck <= pins_sync[2];
      tx_i2s_ws <= pins_sync[1];
      tx_i2s_sd <= pins_sync[0];
    end else begin
      tx_i2s_sck <= rx_i2s_sck;
      tx_i2s_ws <= rx_i2s_ws;
      tx_i2s_sd <= rx_i2s_sd;
    end
  end

  // ************************************************************
  // change detection on received packet fields
  // ************************************************************
  // first value after reset is only captured, not a change
  assign kind_changed = audio_kind_vld && kind_seen_r && (audio_kind != last_kind_r);
  assign audio_info_changed = audio_info_vld && audio_info_seen_r &&
                              (audio_info_checksum != last_audio_info_r);
  assign video_info_changed = video_info_vld && video_info_seen_r &&
                              (video_info_checksum != last_video_info_r);
  assign regen_changed = clk_regen_vld && regen_seen_r &&
                         ((clk_regen_n != last_n_r) || (clk_regen_cts != last_cts_r));

  // last seen audio type
  always @(posedge clk) begin
    if (!rst_b) begin
      last_kind_r <= 4'h0;
      kind_seen_r <= 1'b0;
    end else if (audio_kind_vld) begin
      last_kind_r <= audio_kind;
      kind_seen_r <= 1'b1;
    end
  end

  // last seen audio infoframe checksum
  always @(posedge clk) begin
    if (!rst_b) begin
      last_audio_info_r <= 8'h00;
      audio_info_seen_r <= 1'b0;
    end else if (audio_info_vld) begin
      last_audio_info_r <= audio_info_checksum;
      audio_info_seen_r <= 1'b1;
    end
  end

  // last seen video infoframe checksum
  always @(posedge clk) begin
    if (!rst_b) begin
      last_video_info_r <= 8'h00;
      video_info_seen_r <= 1'b0;
    end else if (video_info_vld) begin
      last_video_info_r <= video_info_checksum;
      video_info_seen_r <= 1'b1;
    end
  end

  // last seen clock regeneration values
  always @(posedge clk) begin
    if (!rst_b) begin
      last_n_r <= 20'h00000;
      last_cts_r <= 20'h00000;
      regen_seen_r <= 1'b0;
    end else if (clk_regen_vld) begin
      last_n_r <= clk_regen_n;
      last_cts_r <= clk_regen_cts;
      regen_seen_r <= 1'b1;
    end
  end

  // gate each change by its enable
  assign clear_request =
    // RQ5 clear on type change
    (kind_changed && audio_config_r[`CFG_CLR_KIND_BIT]) ||
    // RQ6 clear on infoframe change
    (audio_info_changed && audio_config_r[`CFG_CLR_AUDIO_INFO_BIT]) ||
    // RQ7 clear on video infoframe
    (video_info_changed && audio_config_r[`CFG_CLR_VIDEO_INFO_BIT]) ||
    // RQ8 clear on N/CTS change
    (regen_changed && audio_config_r[`CFG_CLR_CLK_REGEN_BIT]);

  // one-cycle FIFO clear pulse
  always @(posedge clk) begin
    if (!rst_b) begin
      audio_fifo_clear <= 1'b0;
    end else begin
      audio_fifo_clear <= clear_request;
    end
  end

  // ************************************************************
  // link and input status
  // ************************************************************
  // RQ10 active and far end locked
  // RQ11 only after input and mode settle
  assign tx_locked_now = st_tx_active && st_rx_locked && st_input_seen && st_mode_settled;

  // status register next value, writes never reach it
  always @* begin
    link_status_nxt = `LINK_STATUS_RESET;
    // RQ9 downstream link ready
    link_status_nxt[`STS_LINK_READY_BIT] = st_link_ready;
    link_status_nxt[`STS_TX_LOCKED_BIT] = tx_locked_now;
    // RQ12 port mode while locked
    if (tx_locked_now) begin
      link_status_nxt[`STS_PORT_MODE_HI:`STS_PORT_MODE_LO] = st_port_mode;
    end
    // RQ13 symbol recovery
    link_status_nxt[`STS_SYMBOLS_VALID_BIT] = st_symbols_ok;
    // RQ14 input PLL lock
    link_status_nxt[`STS_PLL_LOCKED_BIT] = st_pll_lock;
    // RQ15 frequency stable
    link_status_nxt[`STS_FREQ_SETTLED_BIT] = st_input_freq_settled;
  end

  // status storage
  always @(posedge clk) begin
    if (!rst_b) begin
      link_status_r <= `LINK_STATUS_RESET;
    end else begin
      link_status_r <= link_status_nxt;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  // read mux, unmapped offsets read zero
  always @* begin
    rd_data_nxt = reg_rd_data;
    if (reg_rd_en) begin
      if (sel_audio_config) begin
        // RQ17 reserved reads zero
        rd_data_nxt = audio_config_r & `CFG_WRITABLE_MASK;
      end else if (sel_link_status) begin
        rd_data_nxt = link_status_r;
      end else begin
        rd_data_nxt = 8'h00;
      end
    end
  end

  // registered read data
  always @(posedge clk) begin
    if (!rst_b) begin
      reg_rd_data <= 8'h00;
    end else begin
      reg_rd_data <= rd_data_nxt;
    end
  end

endmodule // bridge_audio_cfg_link_status_regs

/* File: rtl/bridge_audio_defines.vh */
// register offsets, field positions, reset values and widths of the audio/status bank
`ifndef BRIDGE_AUDIO_DEFINES_VH
`define BRIDGE_AUDIO_DEFINES_VH

// ************************************************************
// register offsets
// ************************************************************
`define AUDIO_CONFIG_OFFSET 8'h55
`define LINK_STATUS_OFFSET 8'h5A

// ************************************************************
// audio_config fields
// ************************************************************
`define CFG_TDM_PARALLEL_BIT 7
`define CFG_SRC_PIN_OUT_BIT 6
`define CFG_CLR_KIND_BIT 3
`define CFG_CLR_AUDIO_INFO_BIT 2
`define CFG_CLR_VIDEO_INFO_BIT 1
`define CFG_CLR_CLK_REGEN_BIT 0
`define CFG_WRITABLE_MASK 8'hCF
`define AUDIO_CONFIG_RESET 8'h0C

// ************************************************************
// link_and_input_status fields
// ************************************************************
`define STS_LINK_READY_BIT 7
`define STS_TX_LOCKED_BIT 6
`define STS_PORT_MODE_HI 5
`define STS_PORT_MODE_LO 4
`define STS_SYMBOLS_VALID_BIT 3
`define STS_PLL_LOCKED_BIT 2
`define STS_FREQ_SETTLED_BIT 0
`define LINK_STATUS_RESET 8'h00

// ************************************************************
// encodings and widths
// ************************************************************
`define PORT_MODE_DUAL 2'h0
`define PORT_MODE_SINGLE_P0 2'h1
`define PORT_MODE_SINGLE_P1 2'h2
`define PORT_MODE_REPLICATE 2'h3
`define AUDIO_SRC_VIDEO_INPUT 1'h0
`define AUDIO_SRC_LOCAL_PINS 1'h1
`define AUDIO_KIND_W 4
`define CHECKSUM_W 8
`define REGEN_W 20
`define STATUS_SYNC_W 10
`define I2S_W 3

`endif

/* File: rtl/sync2.v */
// two-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ps
module sync2 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst_b,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] stable_r;

  // first stage feeds only the second
  always @(posedge clk) begin
    if (!rst_b) begin
      meta_r <= {WIDTH{1'b0}};
      stable_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;

endmodule // sync2

/* File: testbench/regs_asserts.sv */
// concurrent checks on the audio config and link status bank ports
`timescale 1ns/1ps
`include "bridge_audio_defines.vh"
module regs_asserts (
  input wire clk,
  input wire rst_b,
  input wire [7:0] reg_addr,
  input wire reg_wr_en,
  input wire [7:0] reg_wr_data,
  input wire reg_rd_en,
  input wire [7:0] reg_rd_data,
  input wire audio_source_select,
  input wire tdm_parallel_convert_en,
  input wire audio_clk_from_converter,
  input wire audio_fifo_clear,
  input wire rx_i2s_sd,
  input wire i2s_sd_out,
  input wire i2s_oe,
  input wire tx_i2s_sd,
  input wire audio_kind_vld,
  input wire [3:0] audio_kind,
  input wire far_rx_locked
);
  // ************************************************************
  // shadow of kind-clear enable, last kind, lock-low counter
  // ************************************************************
  reg kind_en_r;
  reg kind_seen_r;
  reg [3:0] kind_last_r;
  reg [2:0] lo_cnt_r;
  always @(posedge clk) begin
    if (!rst_b) begin
      kind_en_r <= 1'h1;
      kind_seen_r <= 1'h0;
      kind_last_r <= 4'h0;
      lo_cnt_r <= 3'h0;
    end else begin
      if (reg_wr_en && reg_addr == `AUDIO_CONFIG_OFFSET)
        kind_en_r <= reg_wr_data[3];
      if (audio_kind_vld) begin
        kind_seen_r <= 1'h1;
        kind_last_r <= audio_kind;
      end
      lo_cnt_r <= far_rx_locked ? 3'h0 : (lo_cnt_r == 3'h7 ? 3'h7 : lo_cnt_r + 3'h1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_cfg_wr;
    reg_wr_en && reg_addr == `AUDIO_CONFIG_OFFSET;
  endsequence
  sequence s_kind_new;
    audio_kind_vld && kind_seen_r && kind_en_r && audio_kind != kind_last_r;
  endsequence
  property p_conv; s_cfg_wr |=> tdm_parallel_convert_en == $past(reg_wr_data[7]); endproperty
  a_conv: assert property (p_conv) else $error("converter enable wrong");
  property p_clksel; audio_clk_from_converter == tdm_parallel_convert_en; endproperty
  a_clksel: assert property (p_clksel) else $error("clock select wrong");
  property p_echo; i2s_oe |=> i2s_sd_out == $past(rx_i2s_sd); endproperty
  a_echo: assert property (p_echo) else $error("pin echo wrong");
  property p_ignore; audio_source_select |-> !i2s_oe; endproperty
  a_ignore: assert property (p_ignore) else $error("echo on local source");
  property p_src; !audio_source_select |=> tx_i2s_sd == $past(rx_i2s_sd); endproperty
  a_src: assert property (p_src) else $error("downstream audio wrong");
  property p_kind; s_kind_new |=> audio_fifo_clear; endproperty
  a_kind: assert property (p_kind) else $error("no fifo clear on kind");
  property p_rsv; reg_rd_en && reg_addr == `AUDIO_CONFIG_OFFSET |=> reg_rd_data[5:4] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
  property p_unmap;
    reg_rd_en && reg_addr != `AUDIO_CONFIG_OFFSET && reg_addr != `LINK_STATUS_OFFSET |=> reg_rd_data == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
  property p_txoff; reg_rd_en && reg_addr == `LINK_STATUS_OFFSET && lo_cnt_r > 3'h3 |=> !reg_rd_data[6]; endproperty
  a_txoff: assert property (p_txoff) else $error("locked without far lock");
endmodule // regs_asserts
bind bridge_audio_cfg_link_status_regs regs_asserts u_chk (.*);

/* File: testbench/far_link_model.sv */
// behavioural far end: link bring-up and deserializer lock
`timescale 1ns/1ps
module far_link_model #(
  parameter LOCK_DLY = 3
) (
  input wire clk,
  input wire link_up,
  input wire [1:0] mode,
  output wire link_detect_done,
  output wire serial_tx_active,
  output wire far_rx_locked,
  output wire link_mode_settled,
  output wire [1:0] link_port_mode
);
  // ************************************************************
  // bring-up counter, all status levels drop at once on link loss, port mode follows mode
  // ************************************************************
  int cnt = 0;
  always @(posedge clk) begin
    cnt <= link_up ? (cnt < 15 ? cnt + 1 : cnt) : 0;
  end
  assign link_detect_done = cnt > 1;
  assign serial_tx_active = cnt > 1;
  assign link_mode_settled = cnt > 2;
  assign far_rx_locked = cnt > LOCK_DLY;
  assign link_port_mode = mode;
endmodule // far_link_model

/* File: testbench/tb.sv */
// self-checking bench for the audio config and link status bank
`timescale 1ns/1ps
`include "bridge_audio_defines.vh"
module tb;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, v;
  logic reg_wr_en = 1'h0, reg_rd_en = 1'h0, audio_source_select = 1'h0, link_up = 1'h0;
  logic rx_i2s_sck = 1'h0, rx_i2s_ws = 1'h0, rx_i2s_sd = 1'h0;
  logic i2s_sck_in = 1'h0, i2s_ws_in = 1'h0, i2s_sd_in = 1'h0;
  logic audio_kind_vld = 1'h0, audio_info_vld = 1'h0, video_info_vld = 1'h0, clk_regen_vld = 1'h0;
  logic [3:0] audio_kind = 4'h0;
  logic [7:0] audio_info_checksum = 8'h00, video_info_checksum = 8'h00;
  logic [19:0] clk_regen_n = 20'h00010, clk_regen_cts = 20'h00000;
  logic valid_input_seen = 1'h0, symbol_recovery_ok = 1'h0, input_pll_lock_raw = 1'h0, freq_detect_stable = 1'h0;
  logic [1:0] mode = 2'h0;
  wire [7:0] reg_rd_data;
  wire tdm_parallel_convert_en, audio_clk_from_converter, audio_fifo_clear, i2s_oe;
  wire i2s_sck_out, i2s_ws_out, i2s_sd_out, tx_i2s_sck, tx_i2s_ws, tx_i2s_sd;
  wire link_detect_done, serial_tx_active, far_rx_locked, link_mode_settled;
  wire [1:0] link_port_mode;
  int err_total = 0;
  int n_checks = 0;
  // ************************************************************
  // clock, instances, shared tasks
  // ************************************************************
  always #2 clk = ~clk;
  far_link_model far (.clk(clk), .link_up(link_up), .mode(mode), .link_detect_done(link_detect_done),
    .serial_tx_active(serial_tx_active), .far_rx_locked(far_rx_locked),
    .link_mode_settled(link_mode_settled), .link_port_mode(link_port_mode));
  bridge_audio_cfg_link_status_regs DUT (.*);
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'h1;
    tick(1);
    reg_wr_en = 1'h0;
    tick(1);
  endtask
  task rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd_en = 1'h1;
    tick(1);
    reg_rd_en = 1'h0;
    v = reg_rd_data;
    tick(1);
  endtask
  task send(input int k, input logic [7:0] x);
    case (k)
      0: begin audio_kind_vld = 1'h1; audio_kind = x[3:0]; end
      1: begin audio_info_vld = 1'h1; audio_info_checksum = x; end
      2: begin video_info_vld = 1'h1; video_info_checksum = x; end
      default: begin clk_regen_vld = 1'h1; clk_regen_cts = {12'h000, x}; end
    endcase
    tick(1);
    {audio_kind_vld, audio_info_vld, video_info_vld, clk_regen_vld} = 4'h0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_regs;
    rd(`AUDIO_CONFIG_OFFSET);
    chk(v, `AUDIO_CONFIG_RESET);
    rd(`LINK_STATUS_OFFSET);
    chk(v, 8'h00);
    wr(`AUDIO_CONFIG_OFFSET, 8'hFF);
    chk({6'h00, tdm_parallel_convert_en, audio_clk_from_converter}, 8'h03);
    rd(`AUDIO_CONFIG_OFFSET);
    chk(v, 8'hCF);
    wr(`LINK_STATUS_OFFSET, 8'hFF);
    wr(8'h56, 8'hFF);
    rd(`LINK_STATUS_OFFSET);
    chk(v, 8'h00);
    rd(8'h56);
    chk(v, 8'h00);
    wr(`AUDIO_CONFIG_OFFSET, 8'h00);
    chk({6'h00, tdm_parallel_convert_en, audio_clk_from_converter}, 8'h00);
    $display("test regs done");
  endtask
  task t_echo;
    wr(`AUDIO_CONFIG_OFFSET, 8'h40);
    for (int i = 0; i < 8; i++) begin
      {rx_i2s_sck, rx_i2s_ws, rx_i2s_sd} = i[2:0];
      tick(1);
      chk({4'h0, i2s_oe, i2s_sck_out, i2s_ws_out, i2s_sd_out}, {4'h0, 1'h1, i[2:0]});
      chk({5'h00, tx_i2s_sck, tx_i2s_ws, tx_i2s_sd}, {5'h00, i[2:0]});
    end
    audio_source_select = 1'h1;
    {i2s_sck_in, i2s_ws_in, i2s_sd_in} = 3'h6;
    {rx_i2s_sck, rx_i2s_ws, rx_i2s_sd} = 3'h1;
    tick(4);
    chk({5'h00, tx_i2s_sck, tx_i2s_ws, tx_i2s_sd}, 8'h06);
    chk({4'h0, i2s_oe, i2s_sck_out, i2s_ws_out, i2s_sd_out}, 8'h00);
    audio_source_select = 1'h0;
    wr(`AUDIO_CONFIG_OFFSET, 8'h00);
    $display("test echo done");
  endtask
  task t_fifo;
    for (int k = 0; k < 4; k++) begin
      send(k, 8'h01);
      chk({7'h00, audio_fifo_clear}, 8'h00);
      wr(`AUDIO_CONFIG_OFFSET, 8'h08 >> k);
      send(k, 8'h02);
      chk({7'h00, audio_fifo_clear}, 8'h01);
      tick(1);
      chk({7'h00, audio_fifo_clear}, 8'h00);
      send(k, 8'h02);
      chk({7'h00, audio_fifo_clear}, 8'h00);
      wr(`AUDIO_CONFIG_OFFSET, ~(8'h08 >> k) & 8'h0F);
      send(k, 8'h03);
      chk({7'h00, audio_fifo_clear}, 8'h00);
      tick(1);
    end
    // N alone changes, CTS repeats
    wr(`AUDIO_CONFIG_OFFSET, 8'h01);
    clk_regen_n = 20'h00020;
    send(3, 8'h03);
    chk({7'h00, audio_fifo_clear}, 8'h01);
    $display("test fifo done");
  endtask
  task t_status;
    {valid_input_seen, symbol_recovery_ok, input_pll_lock_raw, freq_detect_stable} = 4'hF;
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      link_up = 1'h1;
      tick(10);
      wr(`LINK_STATUS_OFFSET, 8'h00);
      rd(`LINK_STATUS_OFFSET);
      chk(v, {2'h3, m[1:0], 4'hD});
      link_up = 1'h0;
      tick(6);
      rd(`LINK_STATUS_OFFSET);
      chk(v, 8'h0D);
    end
    valid_input_seen = 1'h0;
    link_up = 1'h1;
    tick(10);
    rd(`LINK_STATUS_OFFSET);
    chk(v, 8'h8D);
    $display("test status done");
  endtask
  initial begin
    for (int i = 0; i < 20000; i++)
      @(posedge clk);
    err_total++;
    wrap_up;
  end
  initial begin
    tick(2);
    rst_b = 1'h1;
    t_regs;
    t_echo;
    t_fifo;
    t_status;
    wrap_up;
  end
endmodule // tb
